// *** bench/tcis_chk.sv ***
// Purpose: link checks between the host end and the device end
// Assumes: lines sampled on pclk; open-drain lines with pull-up
// Notes:   each quarter bit lasts far longer than the 8-cycle windows used here
`timescale 1ns/100ps
`default_nettype none
module tcis_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic m_sda_oe,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_scl_high_min: assert property ($rose(scl) |-> scl [*8])
    else $error("serial clock high phase too short");
  a_scl_low_min: assert property ($fell(scl) |-> !scl [*8])
    else $error("serial clock low phase too short");
  a_ack_prompt: assert property ($rose(s_sda_oe) |-> !$past(scl, 2) && $past(scl, 8))
    else $error("device drive not shortly after clock fall");
  a_release_low: assert property ($fell(s_sda_oe) |-> !scl)
    else $error("device released data while clock high");
  a_dev_steady: assert property (scl && $past(scl) |-> $stable(s_sda_oe))
    else $error("device changed data while clock high");
  a_ack_hold: assert property ($rose(s_sda_oe) |-> s_sda_oe [*8])
    else $error("device drive too short");
  a_no_contend: assert property ($rose(m_sda_oe) |-> !s_sda_oe)
    else $error("host began pulling data low while device drives");
  a_stop_idle: assert property (scl && $rose(sda) |=> !s_sda_oe [*8])
    else $error("device drives after stop");
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
// Purpose: drives the host over APB and checks device registers across the link
// Assumes: one data byte per host transfer, as the host end provides
// Notes:   pointer auto-increment cannot be reached through this host end
`timescale 1ns/100ps
`default_nettype none
`define CHK(act, exp) begin total_checks++; if ((act) !== (exp)) begin error_cnt++; \
  $display("Error t=%0t got %0h exp %0h", $time, act, exp); end end
module testbench;
  import tcis_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r = 32'h1A37;
  logic pready, pslverr, irq_out_n, chk_on = 1'b0, nv_addr_ok = 1'b0, phase_start = 1'b0;
  logic [6:0] nv_addr = '0;
  logic [3:0] ev = '0;
  logic [7:0] btn = '0, general_input_pin = '0, mask = '0;
  logic [2:0] tally = '0;
  logic nv_ok = 1'b0, rel = 1'b0;
  logic [15:0] esel = 16'hFFFF;
  logic [NUM_CTL-1:0][7:0] ctl_applied;
  logic [32:0] e, exp_q[$];
  int error_cnt = 0, total_checks = 0;
  tcis_i2c_if link ();
  tcis_host tcis_host_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .bus(link));
  tcis_dev tcis_dev_inst (.pclk, .presetn, .bus(link), .nv_addr_ok, .nv_addr, .phase_start,
    .evt_burn_done(ev[3]), .evt_parm_write(ev[2]), .evt_comp_done(ev[1]),
    .evt_mode_entered(ev[0]), .btn_touched(btn), .btn_release_report(rel), .gpi_pin(general_input_pin),
    .gpi_is_input(mask), .input_edge_select(esel), .nonvolatile_copy_ok(nv_ok),
    .burn_tally(tally), .irq_out_n, .ctl_applied);
  tcis_chk tcis_chk_inst (.pclk, .presetn, .m_sda_oe(link.m_sda_oe),
    .s_sda_oe(link.s_sda_oe), .scl(link.scl), .sda(link.sda));
  always #25 pclk = ~pclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // the watcher sees pre-edge values, so it reads the same answer the master takes
  always @(posedge pclk) if (psel && penable && pready === 1'b1 && chk_on) begin
    e = exp_q.pop_front();
    `CHK({pslverr, prdata}, e)
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic c, input logic [32:0] x, output logic [31:0] q);
    int n;
    if (c) exp_q.push_back(x);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; chk_on <= c;
    @(posedge pclk) penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    q = prdata;
    psel <= 1'b0; penable <= 1'b0; chk_on <= 1'b0;
    if (n == 20) begin error_cnt++; test_done(); end
    @(posedge pclk);
  endtask
  task automatic xfer(input logic rd, input logic [6:0] dadr, input logic [7:0] ptr,
                      input logic [7:0] wd, input logic nk, input logic [7:0] ed);
    logic [31:0] q;
    int n;
    apb(1'b1, H_TGT, {16'h0, ptr, 1'b0, dadr}, 1'b0, '0, q);
    apb(1'b1, H_WDAT, {24'h0, wd}, 1'b0, '0, q);
    apb(1'b1, H_CTRL, {30'h0, rd, 1'b1}, 1'b0, '0, q);
    n = 0;
    q = 32'h1;
    while (q[ST_BUSY] !== 1'b0 && n < 4000) begin apb(1'b0, H_STAT, '0, 1'b0, '0, q); n++; end
    if (n == 4000) begin error_cnt++; test_done(); end
    apb(1'b0, H_STAT, '0, 1'b1, {1'b0, 30'h0, nk, 1'b0}, q);
    if (rd) apb(1'b0, H_RDAT, '0, 1'b1, {25'h0, ed}, q);
  endtask
  initial begin
    r = lfsr(r);
    mask <= r[7:0] | 8'h01;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    r = lfsr(r);
    xfer(1'b0, DEF_SADDR, A_COMP, r[7:0], 1'b0, 8'h00);
    `CHK(ctl_applied[0], 8'h00)
    phase_start <= 1'b1;
    @(posedge pclk) phase_start <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK(ctl_applied[0], r[7:0])
    xfer(1'b1, DEF_SADDR, A_COMP, 8'h00, 1'b0, r[7:0]);
    r = lfsr(r);
    ev <= 4'hF; btn <= r[7:0] | 8'h01; general_input_pin <= r[15:8] | 8'h01;
    @(posedge pclk) ev <= 4'h0;
    repeat (8) @(posedge pclk);
    `CHK(irq_out_n, 1'b0)
    xfer(1'b1, DEF_SADDR, A_EVT, 8'h00, 1'b0, 8'h77);
    `CHK(irq_out_n, 1'b1)
    xfer(1'b1, DEF_SADDR, A_EVT, 8'h00, 1'b0, 8'h00);
    xfer(1'b0, DEF_SADDR, A_BTN, ~btn, 1'b0, 8'h00);
    xfer(1'b1, DEF_SADDR, A_BTN, 8'h00, 1'b0, btn);
    xfer(1'b1, DEF_SADDR, A_GPI, 8'h00, 1'b0, general_input_pin & mask);
    // release reporting on, rise-only edges: falling pins must stay silent
    rel <= 1'b1; esel <= 16'h5555; btn <= 8'h00; general_input_pin <= 8'h00;
    repeat (8) @(posedge pclk);
    xfer(1'b1, DEF_SADDR, A_EVT, 8'h00, 1'b0, 8'h04);
    tally <= 3'h4; nv_ok <= 1'b1;
    @(posedge pclk);
    xfer(1'b1, DEF_SADDR, A_PSS, 8'h00, 1'b0, 8'h04);
    nv_addr_ok <= 1'b1; nv_addr <= 7'h15;
    @(posedge pclk);
    xfer(1'b0, DEF_SADDR, A_COMP, 8'h00, 1'b1, 8'h00);
    xfer(1'b1, 7'h15, A_PSS, 8'h00, 1'b0, 8'h04);
    apb(1'b0, 12'h020, '0, 1'b1, {1'b1, 32'h0}, r);
    test_done();
  end
endmodule
`default_nettype wire

// *** design/tcis_dev.sv ***
// Purpose: device end; serial slave port with status and control registers
// Assumes: link lines sampled by pclk; event inputs are pclk pulses
// Notes:   control writes apply at the next processing phase start
// Contract
// - start, address, write bit; device acks match
// - next byte sets register pointer, acked
// - every write data byte acked until stop
// - pointer advances after each written byte
// - read: pointer write, repeated start, read address
// - device returns bytes; master nack then stop
// - pointer advances during sequential reads too
// - own address default, nonvolatile value overrides
// - written values apply at next phase start
// - interrupt low while any flag set
// - reading flag register clears flags, releases interrupt
// - flag raised within one scan period
// - flag 6 on burn finished
// - flag 5 on store write effective
// - flag 4 on configured input edge
// - flag 2 on touch or enabled release
// - flag 1 on compensation finished
// - flag 0 on host-requested mode entered
// - button register: one bit per touched button
// - input levels; non-input pins read zero
// - bit 3 shows nonvolatile copy in use
// - three-bit burn tally, over three uses defaults (here only bit 3 clears; own address still follows nv_addr_ok)
//
// The APB register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module tcis_dev
  import tcis_pkg::*;
(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  tcis_i2c_if.slave                    bus,
  input  wire logic                    nv_addr_ok,
  input  wire logic [6:0]              nv_addr,
  input  wire logic                    phase_start,
  input  wire logic                    evt_burn_done,
  input  wire logic                    evt_parm_write,
  input  wire logic                    evt_comp_done,
  input  wire logic                    evt_mode_entered,
  input  wire logic [7:0]              btn_touched,
  input  wire logic                    btn_release_report,
  input  wire logic [7:0]              gpi_pin,
  input  wire logic [7:0]              gpi_is_input,
  input  wire logic [15:0]             input_edge_select,
  input  wire logic                    nonvolatile_copy_ok,
  input  wire logic [2:0]              burn_tally,
  output logic                         irq_out_n,
  output logic      [NUM_CTL-1:0][7:0] ctl_applied
);
  typedef enum logic [2:0] {S_IDLE = 3'b000, S_RX = 3'b001, S_ACK = 3'b010, S_TX = 3'b011,
                            S_MACK = 3'b100} tcis_sst_t;
  typedef enum logic [1:0] {K_ADDR = 2'b00, K_PTR = 2'b01, K_DATA = 2'b10} tcis_kind_t;

  function automatic logic [3:0] ctl_idx(input logic [7:0] a);
    case (a)
      A_COMP:  ctl_idx = 4'h0;
      A_GPO:   ctl_idx = 4'h1;
      A_DSEL:  ctl_idx = 4'h2;
      A_DLVL:  ctl_idx = 4'h3;
      A_GCFG:  ctl_idx = 4'h4;
      A_GBASE: ctl_idx = 4'h5;
      A_KEYH:  ctl_idx = 4'h6;
      A_KEYL:  ctl_idx = 4'h7;
      A_SRST:  ctl_idx = 4'h8;
      default: ctl_idx = CTL_NONE;
    endcase
  endfunction

  function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
    edge_hit = ((sel == EDGE_RISE || sel == EDGE_BOTH) && rise) ||
               ((sel == EDGE_FALL || sel == EDGE_BOTH) && fall);
  endfunction

  tcis_sst_t                 st, next_st;
  tcis_kind_t                kind, next_kind;
  logic [3:0]                cnt, next_cnt, wi, ri;
  logic [7:0]                sh, next_sh, ptr, next_ptr, rd_val;
  logic                      rd_mode, next_rd_mode, nack, next_nack, sda_oe, next_sda_oe;
  logic                      scl_s, sda_s, scl_d, sda_d, scl_rise, scl_fall, start, stop;
  logic                      do_load, rd_clear, nv_in_use, next_irq;
  logic [6:0]                own_addr;
  logic [NUM_CTL-1:0][7:0]   ctl_w, next_ctl_w, next_ctl_a;
  logic [7:0]                flags, next_flags, set, btn_q, gpi_s, gpi_d, gpi_hit;

  tcis_sync #(.W(2), .INIT(8'hFF)) u_bus (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({bus.scl, bus.sda}),
    .q       ({scl_s, sda_s})
  );
  tcis_sync #(.W(8), .INIT(8'h00)) u_gpi (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (gpi_pin),
    .q       (gpi_s)
  );

  assign bus.s_sda_o  = 1'b0;
  assign bus.s_sda_oe = sda_oe;
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign start    = scl_s && scl_d && sda_d && !sda_s;
  assign stop     = scl_s && scl_d && !sda_d && sda_s;
  assign own_addr = nv_addr_ok ? nv_addr : DEF_SADDR;
  // a tally above three clears the in-use bit; the own address still follows nv_addr_ok
  assign nv_in_use = nonvolatile_copy_ok && burn_tally != BURN_NONE && burn_tally <= BURN_MAX;

  always_comb begin
    ri     = ctl_idx(ptr);
    rd_val = 8'h00;
    case (ptr)
      A_EVT: rd_val = flags;
      A_BTN: rd_val = btn_q;
      A_GPI: rd_val = gpi_s & gpi_is_input;
      A_PSS: begin
        rd_val[PSS_VALID_BIT]  = nv_in_use;
        rd_val[BURN_MSB:0]     = burn_tally;
      end
      default: if (ri != CTL_NONE) rd_val = ctl_w[ri];
    endcase
  end

  always_comb begin
    next_st = st;       next_kind = kind;     next_cnt = cnt;       next_sh = sh;
    next_ptr = ptr;     next_rd_mode = rd_mode; next_nack = nack;   next_sda_oe = sda_oe;
    next_ctl_w = ctl_w;
    do_load  = 1'b0;
    rd_clear = 1'b0;
    wi       = ctl_idx(ptr);
    if (stop) begin
      next_st     = S_IDLE;
      next_sda_oe = 1'b0;
    end else if (start) begin
      next_st     = S_RX;
      next_kind   = K_ADDR;
      next_cnt    = 4'h0;
      next_sda_oe = 1'b0;
    end else begin
      case (st)
        S_RX: if (scl_rise) begin
          next_sh  = {sh[6:0], sda_s};
          next_cnt = cnt + 4'h1;
        end else if (scl_fall && cnt == BYTE_BITS) begin
          next_st     = S_ACK;
          next_sda_oe = 1'b1;
          case (kind)
            K_ADDR: if (sh[7:1] == own_addr) begin
              next_rd_mode = sh[0] == RW_READ;
              next_kind    = K_PTR;
            end else begin
              next_st     = S_IDLE;
              next_sda_oe = 1'b0;
            end
            K_PTR: begin
              next_ptr  = sh;
              next_kind = K_DATA;
            end
            default: begin
              if (wi != CTL_NONE) next_ctl_w[wi] = sh;
              next_ptr = ptr + 8'h01;
            end
          endcase
        end
        S_ACK: if (scl_fall) begin
          if (rd_mode) do_load = 1'b1;
          else begin
            next_st     = S_RX;
            next_cnt    = 4'h0;
            next_sda_oe = 1'b0;
          end
        end
        S_TX: if (scl_fall) begin
          if (cnt == BYTE_BITS) begin
            next_st     = S_MACK;
            next_sda_oe = 1'b0;
          end else begin
            next_sh     = {sh[6:0], 1'b0};
            next_sda_oe = !sh[6];
            next_cnt    = cnt + 4'h1;
          end
        end
        S_MACK: if (scl_rise) begin
          next_nack = sda_s;
        end else if (scl_fall) begin
          if (nack == BIT_NACK) next_st = S_IDLE;
          else do_load = 1'b1;
        end
        default: next_st = S_IDLE;
      endcase
    end
    // loading the byte is the read itself, so the flag clear rides on it
    if (do_load) begin
      next_st     = S_TX;
      next_sh     = rd_val;
      next_sda_oe = !rd_val[7];
      next_cnt    = 4'h1;
      next_ptr    = ptr + 8'h01;
      rd_clear    = ptr == A_EVT;
    end
  end

  always_comb begin
    gpi_hit = 8'h00;
    for (int i = 0; i < 8; i++) begin
      gpi_hit[i] = gpi_is_input[i] && edge_hit(input_edge_select[2*i+:2], gpi_s[i] && !gpi_d[i],
                                               !gpi_s[i] && gpi_d[i]);
    end
    set         = 8'h00;
    set[F_BURN] = evt_burn_done;
    set[F_PARM] = evt_parm_write;
    set[F_GPI]  = |gpi_hit;
    set[F_BTN]  = |(btn_touched & ~btn_q) ||
                  (btn_release_report && |(~btn_touched & btn_q));
    set[F_COMP] = evt_comp_done;
    set[F_MODE] = evt_mode_entered;
    // a new event in the clearing cycle survives the clear
    next_flags = (rd_clear ? 8'h00 : flags) | set;
    next_irq   = !(|next_flags);
    next_ctl_a = phase_start ? ctl_w : ctl_applied;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= S_IDLE;     kind <= K_ADDR;   cnt <= 4'h0;      sh <= 8'h00;
      ptr <= 8'h00;     rd_mode <= 1'b0;  nack <= 1'b0;     sda_oe <= 1'b0;
      scl_d <= 1'b1;    sda_d <= 1'b1;    flags <= 8'h00;   irq_out_n <= 1'b1;
      btn_q <= 8'h00;   gpi_d <= 8'h00;
      ctl_w       <= {NUM_CTL{CTL_RST}};
      ctl_applied <= {NUM_CTL{CTL_RST}};
    end else begin
      st <= next_st;    kind <= next_kind;       cnt <= next_cnt;   sh <= next_sh;
      ptr <= next_ptr;  rd_mode <= next_rd_mode; nack <= next_nack; sda_oe <= next_sda_oe;
      scl_d <= scl_s;   sda_d <= sda_s;          flags <= next_flags; irq_out_n <= next_irq;
      btn_q <= btn_touched; gpi_d <= gpi_s;
      ctl_w       <= next_ctl_w;
      ctl_applied <= next_ctl_a;
    end
  end
endmodule
`default_nettype wire

// *** design/tcis_host.sv ***
// Purpose: host end; runs register write and read transfers on the serial link
// Assumes: APB slave for its own command registers; no clock stretching
// Notes:   one data byte per transfer; serial clock made by a divider
`timescale 1ns/100ps
`default_nettype none
module tcis_host
  import tcis_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  tcis_i2c_if.master       bus
);
  typedef enum logic [1:0] {H_IDLE = 2'b00, H_START = 2'b01, H_SLOT = 2'b10, H_STOP = 2'b11}
    tcis_hst_t;
  localparam logic [15:0] QTR_LAST = 16'(QTR_CYC - 1);

  function automatic tcis_hst_t item(input logic [2:0] s, input logic rd);
    if (s == SEQ_START || (rd && s == SEQ_RSTRT)) item = H_START;
    else if ((!rd && s == SEQ_WSTOP) || s == SEQ_RSTOP) item = H_STOP;
    else item = H_SLOT;
  endfunction

  tcis_hst_t   st, next_st;
  logic [2:0]  seq, next_seq;
  logic [1:0]  q, next_q;
  logic [3:0]  bitn, next_bitn;
  logic [15:0] div, next_div;
  logic        scl_oe, next_scl_oe, sda_oe, next_sda_oe;
  logic [8:0]  rx9, next_rx9, tx9;
  logic        busy, next_busy, nack, next_nack, rd_op, next_rd_op;
  logic [6:0]  saddr, next_saddr;
  logic [7:0]  rptr, next_rptr, wdata, next_wdata, rdata, next_rdata;
  logic [31:0] next_prdata, rdv;
  logic        next_pready, next_pslverr, miss, sda_s, tick, rdslot, apb_wr;

  tcis_sync #(.W(1), .INIT(8'hFF)) u_sda (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (bus.sda),
    .q       (sda_s)
  );

  assign bus.m_scl_o  = 1'b0;
  assign bus.m_sda_o  = 1'b0;
  assign bus.m_scl_oe = scl_oe;
  assign bus.m_sda_oe = sda_oe;

  always_comb begin
    rdslot = rd_op && seq == SEQ_RDATA;
    case (seq)
      SEQ_ADDR:  tx9 = {saddr, RW_WRITE, 1'b1};
      SEQ_PTR:   tx9 = {rptr, 1'b1};
      SEQ_WDATA: tx9 = {wdata, 1'b1};
      SEQ_RADDR: tx9 = {saddr, RW_READ, 1'b1};
      default:   tx9 = {8'hFF, BIT_NACK};
    endcase
  end

  always_comb begin
    rdv  = 32'h0000_0000;
    miss = 1'b0;
    case (paddr)
      H_CTRL: rdv[CTRL_RD] = rd_op;
      H_STAT: begin
        rdv[ST_BUSY] = busy;
        rdv[ST_NACK] = nack;
      end
      H_TGT: begin
        rdv[6:0]            = saddr;
        rdv[TGT_PTR_LSB+:8] = rptr;
      end
      H_WDAT: rdv[7:0] = wdata;
      H_RDAT: rdv[7:0] = rdata;
      default: miss = 1'b1;
    endcase
  end

  always_comb begin
    apb_wr       = psel && penable && pready && pwrite;
    next_pready  = psel && penable && !pready;
    next_prdata  = (psel && penable && !pready) ? rdv : prdata;
    next_pslverr = psel && penable && !pready && miss;
    next_st = st;         next_seq = seq;     next_q = q;         next_bitn = bitn;
    next_scl_oe = scl_oe; next_sda_oe = sda_oe; next_rx9 = rx9;   next_busy = busy;
    next_nack = nack;     next_rd_op = rd_op; next_saddr = saddr; next_rptr = rptr;
    next_wdata = wdata;   next_rdata = rdata;
    tick     = div == QTR_LAST;
    next_div = (busy && !tick) ? div + 16'h0001 : 16'h0000;
    if (apb_wr && !busy) begin
      case (paddr)
        H_CTRL: if (pwdata[CTRL_GO]) begin
          next_busy  = 1'b1;
          next_st    = H_START;
          next_seq   = SEQ_START;
          next_q     = 2'h0;
          next_bitn  = 4'h0;
          next_nack  = 1'b0;
          next_rd_op = pwdata[CTRL_RD];
        end
        H_TGT: begin
          next_saddr = pwdata[6:0];
          next_rptr  = pwdata[TGT_PTR_LSB+:8];
        end
        H_WDAT: next_wdata = pwdata[7:0];
        default: ;
      endcase
    end
    if (busy && tick) begin
      next_q = q + 2'h1;
      case (st)
        H_START: case (q)
          2'h0:    next_sda_oe = 1'b0;
          2'h1:    next_scl_oe = 1'b0;
          2'h2:    next_sda_oe = 1'b1;
          default: next_scl_oe = 1'b1;
        endcase
        H_SLOT: case (q)
          2'h0:    next_sda_oe = !tx9[BYTE_BITS - bitn];
          2'h1:    next_scl_oe = 1'b0;
          2'h2:    next_rx9 = {rx9[7:0], sda_s};
          default: next_scl_oe = 1'b1;
        endcase
        H_STOP: case (q)
          2'h0:    next_sda_oe = 1'b1;
          2'h1:    next_scl_oe = 1'b0;
          2'h2:    next_sda_oe = 1'b0;
          default: ;
        endcase
        default: ;
      endcase
      if (q == 2'h3) begin
        if (st == H_SLOT && bitn != BYTE_BITS) begin
          next_bitn = bitn + 4'h1;
        end else begin
          next_bitn = 4'h0;
          if (st == H_STOP) begin
            next_busy = 1'b0;
            next_st   = H_IDLE;
          end else if (st == H_SLOT && !rdslot && rx9[0]) begin
            // refused byte: abandon the transfer with a stop
            next_nack = 1'b1;
            next_st   = H_STOP;
          end else begin
            next_seq = seq + 3'h1;
            next_st  = item(seq + 3'h1, rd_op);
          end
          if (st == H_SLOT && rdslot) next_rdata = rx9[8:1];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= H_IDLE;      seq <= SEQ_START;  q <= 2'h0;       bitn <= 4'h0;
      div <= 16'h0000;   scl_oe <= 1'b0;    sda_oe <= 1'b0;  rx9 <= 9'h000;
      busy <= 1'b0;      nack <= 1'b0;      rd_op <= 1'b0;   saddr <= DEF_SADDR;
      rptr <= 8'h00;     wdata <= 8'h00;    rdata <= 8'h00;  prdata <= 32'h0000_0000;
      pready <= 1'b0;    pslverr <= 1'b0;
    end else begin
      st <= next_st;         seq <= next_seq;       q <= next_q;           bitn <= next_bitn;
      div <= next_div;       scl_oe <= next_scl_oe; sda_oe <= next_sda_oe; rx9 <= next_rx9;
      busy <= next_busy;     nack <= next_nack;     rd_op <= next_rd_op;   saddr <= next_saddr;
      rptr <= next_rptr;     wdata <= next_wdata;   rdata <= next_rdata;   prdata <= next_prdata;
      pready <= next_pready; pslverr <= next_pslverr;
    end
  end
endmodule
`default_nettype wire

// *** design/tcis_i2c_if.sv ***
// Purpose: two-wire serial link between host end and device end
// Assumes: open-drain lines with pull-up; only the host drives the clock
// Notes:   a line is low when any enabled driver outputs low
`timescale 1ns/100ps
`default_nettype none
interface tcis_i2c_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;
  assign scl = (m_scl_oe && !m_scl_o) ? 1'b0 : 1'b1;
  assign sda = ((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o)) ? 1'b0 : 1'b1;
  modport master (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input scl, sda);
  modport slave  (output s_sda_o, s_sda_oe, input scl, sda);
endinterface
`default_nettype wire

// *** design/tcis_pkg.sv ***
// Purpose: shared constants for the touch controller serial port and its host end
// Assumes: 8-bit register space, 7-bit serial slave address
// Notes:   host timing derives from the pclk rate
`default_nettype none
package tcis_pkg;
  // device register map
  localparam logic [7:0] A_EVT   = 8'h00;
  localparam logic [7:0] A_BTN   = 8'h02;
  localparam logic [7:0] A_GPI   = 8'h07;
  localparam logic [7:0] A_PSS   = 8'h08;
  localparam logic [7:0] A_COMP  = 8'h09;
  localparam logic [7:0] A_GPO   = 8'h0A;
  localparam logic [7:0] A_DSEL  = 8'h0B;
  localparam logic [7:0] A_DLVL  = 8'h0C;
  localparam logic [7:0] A_GCFG  = 8'h0D;
  localparam logic [7:0] A_GBASE = 8'h0E;
  localparam logic [7:0] A_KEYH  = 8'hAC;
  localparam logic [7:0] A_KEYL  = 8'hAD;
  localparam logic [7:0] A_SRST  = 8'hB1;
  localparam int         NUM_CTL  = 9;
  localparam logic [3:0] CTL_NONE = 4'hF;
  localparam logic [7:0] CTL_RST  = 8'h00;
  // event flag positions
  localparam int F_MODE = 0;
  localparam int F_COMP = 1;
  localparam int F_BTN  = 2;
  localparam int F_GPI  = 4;
  localparam int F_PARM = 5;
  localparam int F_BURN = 6;
  // param store state fields
  localparam int         PSS_VALID_BIT = 3;
  localparam int         BURN_MSB      = 2;
  localparam logic [2:0] BURN_NONE     = 3'h0;
  localparam logic [2:0] BURN_MAX      = 3'h3;
  // input edge selection codes
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // serial protocol
  localparam logic [6:0] DEF_SADDR = 7'h2B;
  localparam logic       RW_WRITE  = 1'b0;
  localparam logic       RW_READ   = 1'b1;
  localparam logic       BIT_NACK  = 1'b1;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // host APB map and fields
  localparam logic [11:0] H_CTRL = 12'h000;
  localparam logic [11:0] H_STAT = 12'h004;
  localparam logic [11:0] H_TGT  = 12'h008;
  localparam logic [11:0] H_WDAT = 12'h00C;
  localparam logic [11:0] H_RDAT = 12'h010;
  localparam int CTRL_GO     = 0;
  localparam int CTRL_RD     = 1;
  localparam int ST_BUSY     = 0;
  localparam int ST_NACK     = 1;
  localparam int TGT_PTR_LSB = 8;
  // host transfer sequence steps
  localparam logic [2:0] SEQ_START = 3'h0;
  localparam logic [2:0] SEQ_ADDR  = 3'h1;
  localparam logic [2:0] SEQ_PTR   = 3'h2;
  localparam logic [2:0] SEQ_WDATA = 3'h3;
  localparam logic [2:0] SEQ_RSTRT = 3'h3;
  localparam logic [2:0] SEQ_WSTOP = 3'h4;
  localparam logic [2:0] SEQ_RADDR = 3'h4;
  localparam logic [2:0] SEQ_RDATA = 3'h5;
  localparam logic [2:0] SEQ_RSTOP = 3'h6;
  // host serial clock timing
  localparam int CLK_NS  = 50;
  localparam int SCL_NS  = 10000;
  localparam int QTR_CYC = SCL_NS / (4 * CLK_NS);
endpackage
`default_nettype wire

// *** design/tcis_sync.sv ***
// Purpose: two-stage synchroniser for signals from outside the pclk domain
// Assumes: each bit is an independent level
// Notes:   only the second stage may be read
`timescale 1ns/100ps
`default_nettype none
module tcis_sync #(
  parameter int         W    = 2,
  parameter logic [7:0] INIT = 8'hFF
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= INIT[W-1:0];
      q    <= INIT[W-1:0];
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire
